// ==== verilog/sfts_top.sv ====
// Start-of-conversion force, trigger select and request flag logic
//
// Function
// - Writing one to a force bit sets that slot's request flag.
// - Writing zero to a force bit has no effect on the flag.
// - The force register always reads as zero.
// - Force and hardware clear in one cycle leave the flag set.
// - In that collision the overflow flag stays unchanged.
// - A pending flag starts a conversion only when its slot is granted.
// - Force bits cover all sixteen slots, eight to fifteen in upper bits.
// - Trigger source field sits in bits 24-20, overridden by interrupt select.
// - Source code 00h means software trigger only.
// - Codes 01h to 03h select first CPU timers 0, 1, 2.
// - Code 04h selects the external pin trigger.
// - Codes 05h to 1Ch select PWM 1-12 triggers, A then B.
// - Codes 1Dh to 1Fh select second CPU timers 0, 1, 2.
// - Slot zero control sits at byte offset 40h (word index 10h) and resets to zero.
// - Channel select field in bits 18-15 picks the converted channel.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sfts_top #(
  parameter int unsigned NUM_SLOTS = sfts_pkg::NUM_SLOTS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [2:0] cpu1_timer_tick_out_i,
  input wire logic external_pin_trigger_i,
  input wire logic [11:0] pwm_trigger_a_i,
  input wire logic [11:0] pwm_trigger_b_i,
  input wire logic [2:0] cpu2_timer_tick_out_i,
  input wire logic conv_int_trig_i,
  input wire logic core_ready_i,
  output logic start_valid_o,
  output sfts_pkg::sfts_start_t start_o,
  output logic irq_o
);
  logic wr_en;
  sfts_pkg::sfts_wr_t wr;
  logic wr_ok;
  logic rd_en;
  logic [5:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [31:0] trig_vec;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [NUM_SLOTS-1:0] force_vec;
  logic [NUM_SLOTS-1:0] clr_vec;
  logic [NUM_SLOTS-1:0] ovf_clr_vec;
  logic [NUM_SLOTS-1:0] hw_vec;
  logic [NUM_SLOTS-1:0] ovf_evt_vec;
  logic [NUM_SLOTS-1:0] flags_q;
  logic [NUM_SLOTS-1:0] ovf_q;
  logic [NUM_SLOTS-1:0] intsel_q;
  logic [sfts_pkg::IRQ_W-1:0] istat_q;
  logic [sfts_pkg::IRQ_W-1:0] istat_d;
  logic [sfts_pkg::IRQ_W-1:0] imask_q;
  logic [3:0] grant_slot;
  logic grant;
  logic wr_ctl;
  logic rd_ctl;
  logic [3:0] wr_slot;
  logic [3:0] rd_slot;
  logic [31:0] ctl_new;
  sfts_pkg::sfts_ctl_t ctl_q [NUM_SLOTS];

  function automatic logic [31:0] ctl_word(input sfts_pkg::sfts_ctl_t c);
    logic [31:0] w;
    w = sfts_pkg::CTL_RESET;
    w[sfts_pkg::TRIG_LSB +: sfts_pkg::TRIG_W] = c.trig_sel;
    w[sfts_pkg::CHAN_LSB +: sfts_pkg::CHAN_W] = c.chan_sel;
    w[sfts_pkg::ACQ_LSB +: sfts_pkg::ACQ_W] = c.acq_win;
    return w;
  endfunction

  function automatic logic [3:0] slot_of(input logic [5:0] idx);
    logic [5:0] d;
    d = idx - sfts_pkg::IDX_CTL0;
    return d[4:1];
  endfunction

  function automatic logic is_ctl(input logic [5:0] idx);
    return (idx >= sfts_pkg::IDX_CTL0) && (idx <= sfts_pkg::IDX_CTL_LAST) && !idx[0];
  endfunction

  sfts_axil u_axil (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .awaddr_i(s_axi_awaddr_i),
    .awvalid_i(s_axi_awvalid_i),
    .awready_o(s_axi_awready_o),
    .wdata_i(s_axi_wdata_i),
    .wstrb_i(s_axi_wstrb_i),
    .wvalid_i(s_axi_wvalid_i),
    .wready_o(s_axi_wready_o),
    .bresp_o(s_axi_bresp_o),
    .bvalid_o(s_axi_bvalid_o),
    .bready_i(s_axi_bready_i),
    .araddr_i(s_axi_araddr_i),
    .arvalid_i(s_axi_arvalid_i),
    .arready_o(s_axi_arready_o),
    .rdata_o(s_axi_rdata_o),
    .rresp_o(s_axi_rresp_o),
    .rvalid_o(s_axi_rvalid_o),
    .rready_i(s_axi_rready_i),
    .wr_en_o(wr_en),
    .wr_o(wr),
    .wr_ok_i(wr_ok),
    .rd_en_o(rd_en),
    .rd_idx_o(rd_idx),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // Trigger bus indexed by the source code
  always_comb begin
    trig_vec = '0;
    trig_vec[3:1] = cpu1_timer_tick_out_i;
    trig_vec[4] = external_pin_trigger_i;
    for (int m = 0; m < 12; m++) begin
      trig_vec[5 + 2 * m] = pwm_trigger_a_i[m];
      trig_vec[6 + 2 * m] = pwm_trigger_b_i[m];
    end
    trig_vec[31:29] = cpu2_timer_tick_out_i;
  end

  // Byte lane mask of the current write
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8 * b +: 8] = {8{wr.strb[b]}};
    end
  end

  assign wval = wr.data & wmask;
  assign wr_ctl = is_ctl(wr.idx);
  assign rd_ctl = is_ctl(rd_idx);
  assign wr_slot = slot_of(wr.idx);
  assign rd_slot = slot_of(rd_idx);
  // Control word after merging the written byte lanes
  assign ctl_new = (ctl_word(ctl_q[wr_slot]) & ~wmask) | wval;
  // Only ones are acted on, zeros do nothing
  assign force_vec = (wr_en && wr.idx == sfts_pkg::IDX_FORCE) ?
                     wval[NUM_SLOTS-1:0] : '0;
  assign ovf_clr_vec = (wr_en && wr.idx == sfts_pkg::IDX_OVF) ? wval[NUM_SLOTS-1:0] : '0;

  always_comb begin
    unique case (wr.idx)
      sfts_pkg::IDX_FLAG, sfts_pkg::IDX_OVF, sfts_pkg::IDX_INTSEL,
      sfts_pkg::IDX_ISTAT, sfts_pkg::IDX_FORCE, sfts_pkg::IDX_IMASK: wr_ok = 1'b1;
      default: wr_ok = wr_ctl;
    endcase
  end

  // Lowest pending slot wins the grant
  always_comb begin
    grant_slot = '0;
    for (int s = NUM_SLOTS - 1; s >= 0; s--) begin
      if (flags_q[s]) begin
        grant_slot = 4'(s);
      end
    end
  end

  assign grant = core_ready_i && (flags_q != '0);
  assign clr_vec = grant ? (NUM_SLOTS'(1) << grant_slot) : '0;

  for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
    sfts_slot u_slot (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .trig_i(trig_vec),
      .trig_sel_i(ctl_q[g].trig_sel),
      .int_sel_i(intsel_q[g]),
      .int_trig_i(conv_int_trig_i),
      .force_i(force_vec[g]),
      .clear_i(clr_vec[g]),
      .ovf_clr_i(ovf_clr_vec[g]),
      .hw_o(hw_vec[g]),
      .ovf_evt_o(ovf_evt_vec[g]),
      .flag_o(flags_q[g]),
      .ovf_o(ovf_q[g])
    );
  end

  // Slot control registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        ctl_q[s] <= '0;
      end
    end else if (wr_en && wr_ctl) begin
      ctl_q[wr_slot].trig_sel <= ctl_new[sfts_pkg::TRIG_LSB +: sfts_pkg::TRIG_W];
      ctl_q[wr_slot].chan_sel <= ctl_new[sfts_pkg::CHAN_LSB +: sfts_pkg::CHAN_W];
      ctl_q[wr_slot].acq_win <= ctl_new[sfts_pkg::ACQ_LSB +: sfts_pkg::ACQ_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      intsel_q <= '0;
      imask_q <= '0;
    end else if (wr_en) begin
      if (wr.idx == sfts_pkg::IDX_INTSEL) begin
        intsel_q <= (intsel_q & ~wmask[NUM_SLOTS-1:0]) | wval[NUM_SLOTS-1:0];
      end
      if (wr.idx == sfts_pkg::IDX_IMASK) begin
        imask_q <= (imask_q & ~wmask[sfts_pkg::IRQ_W-1:0]) | wval[sfts_pkg::IRQ_W-1:0];
      end
    end
  end

  // Sticky status, cleared by reading it; a new event wins over the clear
  always_comb begin
    istat_d = istat_q;
    if (rd_en && rd_idx == sfts_pkg::IDX_ISTAT) begin
      istat_d = '0;
    end
    if (ovf_evt_vec != '0) begin
      istat_d[sfts_pkg::IRQ_OVF] = 1'b1;
    end
    if (grant) begin
      istat_d[sfts_pkg::IRQ_START] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      istat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_o <= (istat_d & imask_q) != '0;
    end
  end

  // Conversion start toward the core
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_valid_o <= 1'b0;
      start_o <= '0;
    end else begin
      start_valid_o <= grant;
      if (grant) begin
        start_o.slot <= grant_slot;
        start_o.chan <= ctl_q[grant_slot].chan_sel;
        start_o.acq <= ctl_q[grant_slot].acq_win;
      end
    end
  end

  // Read data mux
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (rd_idx)
      sfts_pkg::IDX_FLAG: rd_data[NUM_SLOTS-1:0] = flags_q;
      sfts_pkg::IDX_OVF: rd_data[NUM_SLOTS-1:0] = ovf_q;
      sfts_pkg::IDX_INTSEL: rd_data[NUM_SLOTS-1:0] = intsel_q;
      sfts_pkg::IDX_ISTAT: rd_data[sfts_pkg::IRQ_W-1:0] = istat_q;
      sfts_pkg::IDX_IMASK: rd_data[sfts_pkg::IRQ_W-1:0] = imask_q;
      sfts_pkg::IDX_FORCE: rd_data = '0;
      default: begin
        if (rd_ctl) begin
          rd_data = ctl_word(ctl_q[rd_slot]);
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  property p_force_sets;
    @(posedge clk_i) disable iff (!rst_n_i)
    force_vec != '0 |=> (flags_q & $past(force_vec)) == $past(force_vec);
  endproperty
  a_force_sets: assert property (p_force_sets)
    else $error("forced flag not set");

  property p_zero_ignored;
    @(posedge clk_i) disable iff (!rst_n_i)
    force_vec == '0 |=> flags_q == (($past(flags_q) & ~$past(clr_vec)) | $past(hw_vec));
  endproperty
  a_zero_ignored: assert property (p_zero_ignored)
    else $error("flag changed without cause");

  property p_force_reads_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    rd_en && rd_idx == sfts_pkg::IDX_FORCE |=> s_axi_rvalid_o && s_axi_rdata_o == '0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("force register read not zero");

  property p_collision_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    (force_vec & clr_vec) != '0 |=> (flags_q & $past(clr_vec)) == $past(clr_vec);
  endproperty
  a_collision_set: assert property (p_collision_set)
    else $error("clear won over force");

  property p_collision_ovf;
    @(posedge clk_i) disable iff (!rst_n_i)
    (force_vec & clr_vec) != '0 && ovf_clr_vec == '0 |=>
      ((ovf_q ^ $past(ovf_q)) & $past(clr_vec)) == '0;
  endproperty
  a_collision_ovf: assert property (p_collision_ovf)
    else $error("overflow changed on collision");

  property p_grant;
    @(posedge clk_i) disable iff (!rst_n_i)
    clr_vec != '0 |-> core_ready_i && (clr_vec & flags_q) == clr_vec ##1 start_valid_o;
  endproperty
  a_grant: assert property (p_grant)
    else $error("start without pending granted slot");

  property p_trig_slot0;
    @(posedge clk_i) disable iff (!rst_n_i)
    !intsel_q[0] && ctl_q[0].trig_sel != sfts_pkg::TRIG_SW_ONLY &&
      trig_vec[ctl_q[0].trig_sel] |=> flags_q[0];
  endproperty
  a_trig_slot0: assert property (p_trig_slot0)
    else $error("selected trigger did not set flag");

  property p_sw_only;
    @(posedge clk_i) disable iff (!rst_n_i)
    !flags_q[0] && !intsel_q[0] && ctl_q[0].trig_sel == sfts_pkg::TRIG_SW_ONLY &&
      !force_vec[0] |=> !flags_q[0];
  endproperty
  a_sw_only: assert property (p_sw_only)
    else $error("software-only slot set by hardware");

  property p_ctl_reset;
    @(posedge clk_i)
    !rst_n_i |=> ctl_word(ctl_q[0]) == sfts_pkg::CTL_RESET;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset)
    else $error("slot zero control not cleared by reset");

  property p_pending;
    @(posedge clk_i) disable iff (!rst_n_i)
    flags_q[0] && !clr_vec[0] |=> flags_q[0];
  endproperty
  a_pending: assert property (p_pending)
    else $error("pending flag dropped without grant");
endmodule
`default_nettype wire

// ==== verilog/sfts_pkg.sv ====
// Shared constants and types of the conversion slot trigger block
package sfts_pkg;
  localparam int unsigned NUM_SLOTS = 16;
  localparam int unsigned NUM_TRIG = 32;
  localparam int unsigned IDX_W = 6;
  localparam logic [5:0] IDX_FLAG = 6'h08;
  localparam logic [5:0] IDX_OVF = 6'h09;
  localparam logic [5:0] IDX_INTSEL = 6'h0A;
  localparam logic [5:0] IDX_ISTAT = 6'h0B;
  localparam logic [5:0] IDX_FORCE = 6'h0D;
  localparam logic [5:0] IDX_IMASK = 6'h0E;
  localparam logic [5:0] IDX_CTL0 = 6'h10;
  localparam logic [5:0] IDX_CTL_LAST = 6'h2E;
  localparam int unsigned TRIG_LSB = 20;
  localparam int unsigned TRIG_W = 5;
  localparam int unsigned CHAN_LSB = 15;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned ACQ_LSB = 0;
  localparam int unsigned ACQ_W = 9;
  localparam logic [4:0] TRIG_SW_ONLY = 5'h00;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_START = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [4:0] trig_sel;
    logic [3:0] chan_sel;
    logic [8:0] acq_win;
  } sfts_ctl_t;

  typedef struct packed {
    logic [3:0] slot;
    logic [3:0] chan;
    logic [8:0] acq;
  } sfts_start_t;

  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] data;
    logic [3:0] strb;
  } sfts_wr_t;
endpackage

// ==== verilog/sfts_axil.sv ====
// AXI4-Lite slave front end producing register write and read strobes
`timescale 1ns/10ps
`default_nettype none
module sfts_axil (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_en_o,
  output sfts_pkg::sfts_wr_t wr_o,
  input wire logic wr_ok_i,
  output logic rd_en_o,
  output logic [5:0] rd_idx_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);
  logic aw_held_q;
  logic w_held_q;
  logic rd_pend_q;

  assign wr_en_o = aw_held_q && w_held_q && !bvalid_o;
  assign rd_en_o = rd_pend_q;

  // Write address and data are taken in either order
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      bvalid_o <= 1'b0;
      bresp_o <= sfts_pkg::RESP_OKAY;
      wr_o <= '0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held_q <= 1'b1;
        awready_o <= 1'b0;
        wr_o.idx <= awaddr_i[7:2];
      end
      if (wvalid_i && wready_o) begin
        w_held_q <= 1'b1;
        wready_o <= 1'b0;
        wr_o.data <= wdata_i;
        wr_o.strb <= wstrb_i;
      end
      if (wr_en_o) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok_i ? sfts_pkg::RESP_OKAY : sfts_pkg::RESP_SLVERR;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // Reads take one cycle to decode, then hold the answer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b1;
      rd_pend_q <= 1'b0;
      rd_idx_o <= '0;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= sfts_pkg::RESP_OKAY;
    end else begin
      if (arvalid_i && arready_o) begin
        arready_o <= 1'b0;
        rd_pend_q <= 1'b1;
        rd_idx_o <= araddr_i[7:2];
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= rd_data_i;
        rresp_o <= rd_ok_i ? sfts_pkg::RESP_OKAY : sfts_pkg::RESP_SLVERR;
      end else if (rvalid_o && rready_i) begin
        rvalid_o <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/sfts_slot.sv ====
// One conversion slot: trigger selection, request flag and overflow flag
`timescale 1ns/10ps
`default_nettype none
module sfts_slot (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] trig_i,
  input wire logic [4:0] trig_sel_i,
  input wire logic int_sel_i,
  input wire logic int_trig_i,
  input wire logic force_i,
  input wire logic clear_i,
  input wire logic ovf_clr_i,
  output logic hw_o,
  output logic ovf_evt_o,
  output logic flag_o,
  output logic ovf_o
);
  // Interrupt select overrides the source field; code zero has no source
  assign hw_o = int_sel_i ? int_trig_i : ((trig_sel_i != sfts_pkg::TRIG_SW_ONLY)
                && trig_i[trig_sel_i]);
  // A hardware trigger on a flag still pending is lost
  assign ovf_evt_o = hw_o && flag_o && !clear_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else begin
      flag_o <= force_i || hw_o || (flag_o && !clear_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ovf_o <= 1'b0;
    end else begin
      ovf_o <= ovf_evt_o || (ovf_o && !ovf_clr_i);
    end
  end
endmodule
`default_nettype wire

// ==== verif/sfts_far_model.sv ====
// Far side model: trigger sources and conversion core readiness
`timescale 1ns/10ps
`default_nettype none
module sfts_far_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  input wire logic [4:0] code_i,
  input wire logic int_i,
  input wire logic ready_en_i,
  output logic [2:0] cpu1_o,
  output logic ext_o,
  output logic [11:0] pwm_a_o,
  output logic [11:0] pwm_b_o,
  output logic [2:0] cpu2_o,
  output logic int_o,
  output logic core_ready_o
);
  logic [31:0] hot;
  assign hot = (fire_i && rst_n_i) ? (32'h1 << code_i) : 32'h0;
  // One-cycle pulse on the source that the code names
  always_ff @(posedge clk_i) begin
    cpu1_o <= hot[3:1];
    ext_o <= hot[4];
    for (int m = 0; m < 12; m++) begin
      pwm_a_o[m] <= hot[5 + 2 * m];
      pwm_b_o[m] <= hot[6 + 2 * m];
    end
    cpu2_o <= hot[31:29];
    int_o <= fire_i && int_i;
  end
  // Core stalls until the bench lets it accept a start
  assign core_ready_o = ready_en_i;
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Register level testbench of the conversion slot trigger block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic fire = 1'h0, int_fire = 1'h0, rdy_en = 1'h0;
  logic [4:0] code = 5'h00;
  wire logic awready, wready, bvalid, arready, rvalid, start_valid, irq, ext, int_trig, core_rdy;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0] cpu1, cpu2;
  wire logic [11:0] pwm_a, pwm_b;
  sfts_pkg::sfts_start_t start;
  sfts_pkg::sfts_start_t starts[$];
  int error_cnt = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs, wresp;

  always #2.5 clk_i = ~clk_i;

  sfts_top i_dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready),
    .cpu1_timer_tick_out_i(cpu1),
    .external_pin_trigger_i(ext),
    .pwm_trigger_a_i(pwm_a),
    .pwm_trigger_b_i(pwm_b),
    .cpu2_timer_tick_out_i(cpu2),
    .conv_int_trig_i(int_trig),
    .core_ready_i(core_rdy),
    .start_valid_o(start_valid),
    .start_o(start),
    .irq_o(irq)
  );

  sfts_far_model i_far (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .fire_i(fire),
    .code_i(code),
    .int_i(int_fire),
    .ready_en_i(rdy_en),
    .cpu1_o(cpu1),
    .ext_o(ext),
    .pwm_a_o(pwm_a),
    .pwm_b_o(pwm_b),
    .cpu2_o(cpu2),
    .int_o(int_trig),
    .core_ready_o(core_rdy)
  );

  always @(posedge clk_i) begin
    if (start_valid === 1'h1) begin
      starts.push_back(start);
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("[FAIL] %0t wait limit reached", $time);
    final_report();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Write; pr opens core readiness for the one cycle in which the write lands
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit pr = 1'b0);
    int n;
    @(posedge clk_i);
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (pr) rdy_en <= awvalid && awready;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    wresp = bresp;
    bready <= 1'h0;
    if (n == 64) hang();
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    int n;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
    if (n == 64) hang();
    chk(rd, exp, msg);
  endtask

  task automatic pulse(input logic [4:0] c, input logic i = 1'h0);
    @(posedge clk_i);
    fire <= 1'h1;
    code <= c;
    int_fire <= i;
    @(posedge clk_i);
    fire <= 1'h0;
    int_fire <= 1'h0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic drain();
    @(posedge clk_i);
    rdy_en <= 1'h1;
    repeat (20) @(posedge clk_i);
    rdy_en <= 1'h0;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    hang();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rchk(8'h40, 32'h0, "ctl0 reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h01F7_81FF, "ctl0 fields");
    wr(8'h40, 32'h0);
    rchk(8'h3C, 32'h0, "unmapped read");
    chk({30'h0, rs}, {30'h0, sfts_pkg::RESP_SLVERR}, "unmapped rresp");
    wr(8'h3C, 32'h1);
    chk({30'h0, wresp}, {30'h0, sfts_pkg::RESP_SLVERR}, "unmapped bresp");
    $display("test map done");
    starts.delete();
    wr(8'h34, 32'h0000_8001);
    rchk(8'h20, 32'h8001, "force set");
    rchk(8'h34, 32'h0, "force reads zero");
    wr(8'h34, 32'h0);
    rchk(8'h20, 32'h8001, "zero write ignored");
    chk(32'(starts.size()), 32'h0, "no start without grant");
    drain();
    chk((starts.size() == 2) ? {24'h0, starts[0].slot, starts[1].slot} : 32'hX, 32'h0F, "order");
    rchk(8'h20, 32'h0, "flags cleared by grant");
    wr(8'h34, 32'h20);
    starts.delete();
    wr(8'h34, 32'h20, 1'b1);
    rchk(8'h20, 32'h20, "force beats clear");
    rchk(8'h24, 32'h0, "overflow untouched");
    chk(32'(starts.size()), 32'h1, "collision grant");
    drain();
    $display("test force done");
    for (int c = 0; c < 32; c++) begin
      wr(8'h40, {7'h00, c[4:0], 1'h0, c[3:0], 6'h00, c[8:0]});
      starts.delete();
      pulse(5'((c % 31) + 1));
      rchk(8'h20, 32'h0, "other source");
      pulse(c[4:0]);
      rchk(8'h20, (c == 0) ? 32'h0 : 32'h1, "own source");
      drain();
      chk(32'(starts.size()), (c == 0) ? 32'h0 : 32'h1, "start count");
      if (c != 0 && starts.size() > 0) begin
        chk({15'h0, starts[0]}, {15'h0, 4'h0, c[3:0], c[8:0]}, "start fields");
      end
    end
    $display("test trigger table done");
    wr(8'h48, 32'h0040_0000);
    pulse(5'h04);
    pulse(5'h04);
    rchk(8'h24, 32'h2, "overflow sticky");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(8'h38, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rchk(8'h2C, 32'h3, "status");
    rchk(8'h2C, 32'h0, "status cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(8'h24, 32'h2);
    rchk(8'h24, 32'h0, "overflow cleared");
    drain();
    $display("test overflow done");
    wr(8'h28, 32'h2);
    pulse(5'h04);
    rchk(8'h20, 32'h0, "select overrides field");
    pulse(5'h00, 1'h1);
    rchk(8'h20, 32'h2, "interrupt trigger");
    drain();
    $display("test interrupt select done");
    final_report();
  end
endmodule
`default_nettype wire
